// *** perp_core.sv ***
`timescale 1ns/1ps
module perp_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  perp_if.core port,
  input wire logic legacyMode,
  input wire logic lockedTlpSeen,
  input wire logic logPop,
  output logic cplValid,
  output logic [2:0] cplStatus,
  output logic cplLocked,
  output logic [15:0] cplRequesterId,
  output logic [7:0] cplTag,
  output logic [2:0] cplTc,
  output logic [1:0] cplAttr,
  output logic [11:0] cplByteCount,
  output logic [6:0] cplLowerAddr,
  output logic [4:0] rootErrMsgNum,
  output logic [127:0] headerLogHead,
  output logic [2:0] logCount,
  output logic [7:0] errCount
);
  typedef struct packed {
    logic ready;
    logic [2:0] busy;
    logic cplValid;
    logic [2:0] cplStatus;
    logic cplLocked;
    logic [47:0] cplHdr;
    logic [4:0] msgNum;
    logic [2:0] count;
    logic [1:0] wrPtr;
    logic [1:0] rdPtr;
    logic logSet;
    logic [7:0] errCount;
    logic [127:0] head;
  } perp_core_t;

  perp_core_t st, next_st;
  logic [127:0] logMem [perp_pkg::LOG_DEPTH];
  logic takeUr, takeCa, anyErr, push, pop;

  function automatic logic isAccepted(input logic req, input logic rdy);
    return req & rdy;
  endfunction

  always_comb begin
    takeUr = isAccepted(port.errUnsupportedRequest, st.ready);
    takeCa = isAccepted(port.errCplAbort, st.ready) & ~port.errUnsupportedRequest;
    anyErr = takeUr | takeCa | port.errAcs | port.errOther;
    push = anyErr & (st.count != 3'(perp_pkg::LOG_DEPTH));
    pop = logPop & (st.count != 3'h0);
    next_st = st;
    next_st.cplValid = 1'b0;
    next_st.msgNum = port.aerIntMsgNum;
    if (st.busy != 3'h0) begin
      next_st.busy = st.busy - 3'h1;
    end else begin
      next_st.ready = 1'b1;
    end
    if ((takeUr | takeCa) & ~port.errPosted) begin
      next_st.ready = 1'b0;
      next_st.busy = 3'(perp_pkg::CPL_BUSY_CYCLES - 1);
      next_st.cplValid = 1'b1;
      next_st.cplStatus = takeUr ? perp_pkg::CPL_UR : perp_pkg::CPL_CA;
      next_st.cplHdr = port.errTlpCplHeader;
      if (legacyMode) begin
        next_st.cplLocked = port.errLocked;
      end else begin
        next_st.cplLocked = lockedTlpSeen;
      end
    end
    if (anyErr) begin
      next_st.errCount = st.errCount + 8'h01;
    end
    next_st.count = st.count + 3'(push) - 3'(pop);
    if (push) begin
      next_st.wrPtr = st.wrPtr + 2'h1;
    end
    if (pop) begin
      next_st.rdPtr = st.rdPtr + 2'h1;
    end
    next_st.logSet = (next_st.count == 3'(perp_pkg::LOG_DEPTH));
    next_st.head = logMem[st.rdPtr];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      logMem[st.wrPtr] <= port.errAerHeaderLog;
    end
  end

  assign port.errCplReady = st.ready;
  assign port.errAerHeaderLogSet = st.logSet;
  assign cplValid = st.cplValid;
  assign cplStatus = st.cplStatus;
  assign cplLocked = st.cplLocked;
  assign cplRequesterId = st.cplHdr[perp_pkg::RID_HI:perp_pkg::RID_LO];
  assign cplTag = st.cplHdr[perp_pkg::TAG_HI:perp_pkg::TAG_LO];
  assign cplTc = st.cplHdr[perp_pkg::TC_HI:perp_pkg::TC_LO];
  assign cplAttr = st.cplHdr[perp_pkg::ATTR_HI:perp_pkg::ATTR_LO];
  assign cplByteCount = st.cplHdr[perp_pkg::BCNT_HI:perp_pkg::BCNT_LO];
  assign cplLowerAddr = st.cplHdr[perp_pkg::LADDR_HI:perp_pkg::LADDR_LO];
  assign rootErrMsgNum = st.msgNum;
  assign headerLogHead = st.head;
  assign logCount = st.count;
  assign errCount = st.errCount;
endmodule

// *** perp_pkg.sv ***
package perp_pkg;
  localparam int HDR_W = 48;
  localparam int LOG_W = 128;
  localparam int MSG_W = 5;
  localparam int LADDR_HI = 47;
  localparam int LADDR_LO = 41;
  localparam int BCNT_HI = 40;
  localparam int BCNT_LO = 29;
  localparam int TC_HI = 28;
  localparam int TC_LO = 26;
  localparam int ATTR_HI = 25;
  localparam int ATTR_LO = 24;
  localparam int RID_HI = 23;
  localparam int RID_LO = 8;
  localparam int TAG_HI = 7;
  localparam int TAG_LO = 0;
  localparam int LOG_DEPTH = 4;
  localparam int CPL_BUSY_CYCLES = 4;
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;
  typedef enum logic [1:0] {
    PERP_ERR_UR,
    PERP_ERR_CA,
    PERP_ERR_ACS,
    PERP_ERR_OTHER
  } perp_err_t;
endpackage

// *** perp_if.sv ***
`timescale 1ns/1ps
interface perp_if;
  logic errUnsupportedRequest;
  logic errCplAbort;
  logic errAcs;
  logic errOther;
  logic errLocked;
  logic errPosted;
  logic [47:0] errTlpCplHeader;
  logic [127:0] errAerHeaderLog;
  logic [4:0] aerIntMsgNum;
  logic errCplReady;
  logic errAerHeaderLogSet;
  modport core (
    input errUnsupportedRequest, errCplAbort, errAcs, errOther, errLocked, errPosted,
    input errTlpCplHeader, errAerHeaderLog, aerIntMsgNum,
    output errCplReady, errAerHeaderLogSet
  );
  modport user (
    output errUnsupportedRequest, errCplAbort, errAcs, errOther, errLocked, errPosted,
    output errTlpCplHeader, errAerHeaderLog, aerIntMsgNum,
    input errCplReady, errAerHeaderLogSet
  );
endinterface

// *** perp_user.sv ***
`timescale 1ns/1ps
module perp_user (
  input wire logic ref_clk,
  input wire logic sys_rst,
  perp_if.user port,
  input wire logic reqValid,
  input wire perp_pkg::perp_err_t reqKind,
  input wire logic reqLocked,
  input wire logic reqPosted,
  input wire logic [47:0] reqCplHeader,
  input wire logic [127:0] reqHeaderLog,
  input wire logic [4:0] msgNum,
  output logic reqReady,
  output logic headerNotNeeded
);
  typedef struct packed {
    logic pend;
    logic [1:0] kind;
    logic locked;
    logic posted;
    logic [47:0] hdr;
    logic [127:0] log;
    logic fire;
    logic [4:0] msg;
    logic logSet;
  } perp_user_t;

  perp_user_t st, next_st;
  logic needRdy, go;

  always_comb begin
    next_st = st;
    next_st.fire = 1'b0;
    next_st.msg = msgNum;
    next_st.logSet = port.errAerHeaderLogSet;
    needRdy = (st.kind == 2'(perp_pkg::PERP_ERR_UR)) | (st.kind == 2'(perp_pkg::PERP_ERR_CA));
    go = st.pend & (~needRdy | port.errCplReady) & ~st.fire;
    if (go) begin
      next_st.pend = 1'b0;
      next_st.fire = 1'b1;
    end
    if (reqValid & ~next_st.pend & ~st.fire) begin
      next_st.pend = 1'b1;
      next_st.kind = 2'(reqKind);
      next_st.locked = reqLocked;
      next_st.posted = reqPosted;
      next_st.hdr = reqCplHeader;
      next_st.log = reqHeaderLog;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.errUnsupportedRequest = st.fire & (st.kind == 2'(perp_pkg::PERP_ERR_UR));
  assign port.errCplAbort = st.fire & (st.kind == 2'(perp_pkg::PERP_ERR_CA));
  assign port.errAcs = st.fire & (st.kind == 2'(perp_pkg::PERP_ERR_ACS));
  assign port.errOther = st.fire & (st.kind == 2'(perp_pkg::PERP_ERR_OTHER));
  assign port.errLocked = st.fire & st.locked;
  assign port.errPosted = st.fire & st.posted;
  assign port.errTlpCplHeader = st.hdr;
  assign port.errAerHeaderLog = st.log;
  assign port.aerIntMsgNum = st.msg;
  assign reqReady = ~st.pend & ~st.fire;
  assign headerNotNeeded = st.logSet;
endmodule

// *** perp_checker.sv ***
`timescale 1ns/1ps
module perp_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic errUnsupportedRequest,
  input wire logic errCplAbort,
  input wire logic errAcs,
  input wire logic errOther,
  input wire logic errLocked,
  input wire logic errPosted,
  input wire logic errCplReady
);
  logic anyErr;
  assign anyErr = errUnsupportedRequest | errCplAbort | errAcs | errOther;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence takeS;
    (errUnsupportedRequest || errCplAbort) && errCplReady && !errPosted;
  endsequence
  busy_hold_a: assert property (takeS |=> !errCplReady[*4]) else $error("ready not low");
  ready_back_a: assert property (takeS |=> ##4 errCplReady) else $error("ready not back");
  ur_guard_a: assert property (errUnsupportedRequest |-> errCplReady) else $error("ur early");
  ca_guard_a: assert property (errCplAbort |-> errCplReady) else $error("ca early");
  ur_pulse_a: assert property (errUnsupportedRequest |=> !errUnsupportedRequest)
    else $error("ur long");
  acs_pulse_a: assert property (errAcs |=> !errAcs) else $error("acs long");
  lock_qual_a: assert property (errLocked |-> anyErr) else $error("lone lock");
  post_qual_a: assert property (errPosted |-> anyErr) else $error("lone post");
endmodule

// *** pcie_error_report_port_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module pcie_error_report_port_tb;
  logic ref_clk = 0, sys_rst = 1, legacyMode = 0, lockedTlpSeen = 0, logPop = 0;
  logic reqValid = 0, reqLocked = 0, reqPosted = 0, reqReady, headerNotNeeded, cplValid, cplLocked;
  perp_pkg::perp_err_t reqKind = perp_pkg::PERP_ERR_UR;
  logic [47:0] reqCplHeader = 48'h0, hdr = 48'hA5C3_1234_5678;
  logic [127:0] reqHeaderLog = 128'h0, headerLogHead;
  logic [4:0] msgNum = 5'h0, rootErrMsgNum;
  logic [2:0] cplStatus, cplTc, logCount;
  logic [15:0] cplRequesterId;
  logic [7:0] cplTag, errCount, e;
  logic [1:0] cplAttr;
  logic [11:0] cplByteCount;
  logic [6:0] cplLowerAddr;
  int failures = 0, checksDone = 0;
  perp_if port ();
  perp_core i_perp_core (.ref_clk, .sys_rst, .port, .legacyMode, .lockedTlpSeen, .logPop,
    .cplValid, .cplStatus, .cplLocked, .cplRequesterId, .cplTag, .cplTc, .cplAttr,
    .cplByteCount, .cplLowerAddr, .rootErrMsgNum, .headerLogHead, .logCount, .errCount);
  perp_user i_perp_user (.ref_clk, .sys_rst, .port, .reqValid, .reqKind, .reqLocked,
    .reqPosted, .reqCplHeader, .reqHeaderLog, .msgNum, .reqReady, .headerNotNeeded);
  perp_checker i_perp_checker (.ref_clk, .sys_rst,
    .errUnsupportedRequest(port.errUnsupportedRequest),
    .errCplAbort(port.errCplAbort), .errAcs(port.errAcs), .errOther(port.errOther),
    .errLocked(port.errLocked), .errPosted(port.errPosted), .errCplReady(port.errCplReady));
  initial forever #4 ref_clk = ~ref_clk;
  task end_of_test;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task send(perp_pkg::perp_err_t k, logic lk, logic ps, logic [127:0] lg);
    for (int i = 0; i < 20 && reqReady !== 1'b1; i++) step(1);
    `CHK(reqReady, 1'b1)
    reqKind = k;
    reqLocked = lk;
    reqPosted = ps;
    reqCplHeader = hdr;
    reqHeaderLog = lg;
    reqValid = 1;
    step(1);
    reqValid = 0;
  endtask
  task waitCpl;
    for (int i = 0; i < 12 && cplValid !== 1'b1; i++) step(1);
    `CHK(cplValid, 1'b1)
  endtask
  task t_ur;
    send(perp_pkg::PERP_ERR_UR, 0, 0, 128'h11);
    waitCpl();
    `CHK(cplStatus, perp_pkg::CPL_UR)
    `CHK({cplLowerAddr, cplByteCount, cplTc, cplAttr, cplRequesterId, cplTag}, hdr)
    `CHK(cplLocked, 1'b0)
    $display("ur done");
  endtask
  task t_lock;
    legacyMode = 1;
    send(perp_pkg::PERP_ERR_CA, 1, 0, 128'h22);
    waitCpl();
    `CHK(cplStatus, perp_pkg::CPL_CA)
    `CHK(cplLocked, 1'b1)
    {legacyMode, lockedTlpSeen} = 2'h1;
    send(perp_pkg::PERP_ERR_UR, 0, 0, 128'h33);
    waitCpl();
    `CHK(cplLocked, 1'b1)
    lockedTlpSeen = 0;
    $display("lock done");
  endtask
  task t_post;
    send(perp_pkg::PERP_ERR_CA, 0, 1, 128'h44);
    repeat (8) begin
      step(1);
      `CHK(cplValid, 1'b0)
    end
    `CHK(port.errCplReady, 1'b1)
    $display("post done");
  endtask
  task t_full;
    e = errCount;
    send(perp_pkg::PERP_ERR_ACS, 0, 1, 128'h55);
    step(4);
    `CHK(errCount, e + 8'h01)
    `CHK(logCount, 3'h4)
    `CHK(headerNotNeeded, 1'b1)
    `CHK(headerLogHead, 128'h11)
    logPop = 1;
    step(1);
    logPop = 0;
    step(2);
    `CHK(logCount, 3'h3)
    `CHK(headerLogHead, 128'h22)
    msgNum = 5'h13;
    step(3);
    `CHK(rootErrMsgNum, 5'h13)
    $display("full done");
  endtask
  initial begin
    step(16);
    sys_rst = 0;
    step(1);
    t_ur();
    t_lock();
    t_post();
    t_full();
    end_of_test();
  end
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
endmodule
